// ### dual_clock_fifo_port_flags.sv
// Port and flag logic of a unidirectional 36-bit FIFO with bus matching.
// Assumes port clocks and all pins arrive asynchronously and are sampled
// on sys_clk_i, which must run well above twice either port clock.
//
// Summary of operation
// [R1] Almost-empty low on read clock when stored words at or below offset
// [R2] Almost-full low on write clock when free places at or below offset
// [R3] Write port takes a 36-bit input-only data bus
// [R4] Read port drives a 36-bit output-only data bus
// [R5] Select high at master reset: big-endian, most significant part first
// [R6] Select low at master reset: little-endian, least significant first
// [R7] After master reset select high is standard, low is fall-through
// [R8] Controller keeps the timing mode select level static afterwards
// [R9] Bus-match high: byte or word read width by size; low: long-word
// [R10] Controller keeps the bus-match select level static
// [R11] Write transfers and full-side flags follow write clock rising edges
// [R12] Read transfers and empty-side flags follow read clock rising edges
// [R13] Write edge acts only while write chip select is low
// [R14] Write data pins are high impedance while write select is high
// [R15] Read edge acts only while read chip select is low, except the fall-through head word load
// [R16] Read data pins are high impedance while read select is high
// [R17] Standard mode: combined pin shows whether memory holds no words
// [R18] Fall-through mode: combined pin shows valid data on read outputs
// [R19] Port edges act only while that port's enable is high, except the fall-through head word load on a read edge
// [R20] Combined write pin shows full in standard, space in fall-through
// [R21] Endian and width choice captured at master reset, then held
`timescale 1ns/1ps
`include "fifo_port_regs.svh"
module dual_clock_fifo_port_flags (
  input  wire logic                    sys_clk_i,
  input  wire logic                    srst_i,
  input  wire logic                    clk_en_i,
  input  wire logic                    master_reset_n_i,
  input  wire logic                    write_port_clk_i,
  input  wire logic                    read_port_clk_i,
  input  wire logic                    write_port_select_n_i,
  input  wire logic                    read_port_select_n_i,
  input  wire logic                    write_port_enable_i,
  input  wire logic                    read_port_enable_i,
  input  wire logic [`FIFO_DATA_W-1:0] write_port_data_i,
  input  wire logic                    endian_or_fallthrough_sel_i,
  input  wire logic                    bus_width_match_sel_i,
  input  wire logic                    size_byte_sel_i,
  input  wire logic [`FIFO_CNT_W-1:0]  almost_empty_offset_i,
  input  wire logic [`FIFO_CNT_W-1:0]  almost_full_offset_i,
  output logic                         write_port_data_oe_o,
  output logic      [`FIFO_DATA_W-1:0] read_port_data_o,
  output logic                         read_port_data_oe_o,
  output logic                         empty_or_out_ready_o,
  output logic                         full_or_in_ready_o,
  output logic                         almost_empty_n_o,
  output logic                         almost_full_n_o
);

  // --------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------
  logic [`PIN_W-1:0]        pins_raw;
  logic [`PIN_W-1:0]        pins_s;
  logic                     mrst_n_s;
  logic                     wclk_s;
  logic                     rclk_s;
  logic                     wsel_n_s;
  logic                     rsel_n_s;
  logic                     wen_s;
  logic                     ren_s;
  logic                     mode_sel_s;
  logic                     bus_match_s;
  logic                     size_byte_s;
  logic [`FIFO_CNT_W-1:0]   empty_offset_s;
  logic [`FIFO_CNT_W-1:0]   full_offset_s;
  logic [`FIFO_DATA_W-1:0]  wdata_s;

  assign pins_raw = {master_reset_n_i, write_port_clk_i, read_port_clk_i,
                     write_port_select_n_i, read_port_select_n_i,
                     write_port_enable_i, read_port_enable_i,
                     endian_or_fallthrough_sel_i, bus_width_match_sel_i,
                     size_byte_sel_i, almost_empty_offset_i,
                     almost_full_offset_i, write_port_data_i};

  // Data goes through the same depth as the clock pin, so the word seen
  // with a detected edge is the word that stood at that edge.
  pin_sync #(
    .WIDTH (`PIN_W)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .async_i   (pins_raw),
    .sync_o    (pins_s)
  );

  assign {mrst_n_s, wclk_s, rclk_s, wsel_n_s, rsel_n_s, wen_s, ren_s,
          mode_sel_s, bus_match_s, size_byte_s, empty_offset_s,
          full_offset_s, wdata_s} = pins_s;

  // --------------------------------------------------------------------
  // Port clock edge detection
  // --------------------------------------------------------------------
  logic wclk_prev_q;
  logic rclk_prev_q;
  logic wr_edge;
  logic rd_edge;
  logic wr_edge_q;
  logic rd_edge_q;
  logic in_mrst;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wclk_prev_q <= 1'b0;
      rclk_prev_q <= 1'b0;
      wr_edge_q   <= 1'b0;
      rd_edge_q   <= 1'b0;
    end else if (clk_en_i) begin
      wclk_prev_q <= wclk_s;
      rclk_prev_q <= rclk_s;
      wr_edge_q   <= wr_edge;
      rd_edge_q   <= rd_edge;
    end
  end

  assign wr_edge = wclk_s & ~wclk_prev_q;  // [R11]
  assign rd_edge = rclk_s & ~rclk_prev_q;  // [R12]
  assign in_mrst = ~mrst_n_s;

  // --------------------------------------------------------------------
  // Configuration
  // --------------------------------------------------------------------
  fifo_port_pkg::width_mode_e width_mode_q;
  logic                       big_endian_q;
  logic                       fallthrough_q;
  logic [1:0]                 lanes_m1;

  // The select pin is sampled throughout master reset, so the last
  // level before release is the one kept.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      big_endian_q <= 1'b0;
      width_mode_q <= fifo_port_pkg::WIDTH_LONG;
    end else if (clk_en_i && in_mrst) begin
      big_endian_q <= mode_sel_s;  // [R5] [R6] [R21]
      if (!bus_match_s) begin
        width_mode_q <= fifo_port_pkg::WIDTH_LONG;  // [R9] [R21]
      end else if (size_byte_s) begin
        width_mode_q <= fifo_port_pkg::WIDTH_BYTE;  // [R9]
      end else begin
        width_mode_q <= fifo_port_pkg::WIDTH_WORD;  // [R9]
      end
    end
  end

  // Mode is followed live after reset; a change mid-stream is not
  // guarded against, the controller must hold it.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fallthrough_q <= 1'b0;
    end else if (clk_en_i && !in_mrst) begin
      fallthrough_q <= ~mode_sel_s;  // [R7] [R8]
    end
  end

  always_comb begin
    unique case (width_mode_q)
      fifo_port_pkg::WIDTH_LONG: lanes_m1 = `LANES_M1_LONG;
      fifo_port_pkg::WIDTH_WORD: lanes_m1 = `LANES_M1_WORD;
      fifo_port_pkg::WIDTH_BYTE: lanes_m1 = `LANES_M1_BYTE;
      default:                   lanes_m1 = `LANES_M1_LONG;
    endcase
  end

  // --------------------------------------------------------------------
  // Transfer qualification
  // --------------------------------------------------------------------
  logic [`FIFO_CNT_W-1:0]  count_q;
  logic [`FIFO_ADDR_W-1:0] wr_ptr_q;
  logic [`FIFO_ADDR_W-1:0] rd_ptr_q;
  logic                    mem_full;
  logic                    mem_nonempty;
  logic                    wr_access;
  logic                    rd_access;
  logic                    push;
  logic                    std_adv;
  logic                    std_load;
  logic                    fw_auto;
  logic                    fw_adv;
  logic                    fw_next;
  logic                    fw_drain;
  logic                    load;
  logic                    adv;
  logic                    out_valid_q;
  logic [1:0]              lane_q;
  logic [1:0]              rem_q;

  assign mem_full     = (count_q == `FIFO_DEPTH);
  assign mem_nonempty = (count_q != '0);

  assign wr_access = wr_edge & ~wsel_n_s & wen_s & ~in_mrst;  // [R13] [R19]
  assign rd_access = rd_edge & ~rsel_n_s & ren_s & ~in_mrst;  // [R15] [R19]
  assign push      = wr_access & ~mem_full;  // [R3] [R11]

  // Standard mode: a read either steps to the next lane of the held
  // long-word or fetches a new one from memory.
  assign std_adv  = ~fallthrough_q & rd_access & (rem_q != 2'h0);
  assign std_load = ~fallthrough_q & rd_access & (rem_q == 2'h0)
                  & mem_nonempty;  // [R12]

  // Fall-through mode: the head word moves to the outputs by itself on
  // a read clock edge, with no enable needed.
  assign fw_auto  = fallthrough_q & rd_edge & ~in_mrst & ~out_valid_q
                  & mem_nonempty;  // [R18]
  assign fw_adv   = fallthrough_q & rd_access & out_valid_q
                  & (rem_q != 2'h0);
  assign fw_next  = fallthrough_q & rd_access & out_valid_q
                  & (rem_q == 2'h0) & mem_nonempty;
  assign fw_drain = fallthrough_q & rd_access & out_valid_q
                  & (rem_q == 2'h0) & ~mem_nonempty;

  assign load = std_load | fw_auto | fw_next;
  assign adv  = std_adv | fw_adv;

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic [`FIFO_DATA_W-1:0] mem_q [0:`FIFO_DEPTH-1];

  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i && push) begin
      mem_q[wr_ptr_q] <= wdata_s;  // [R3]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (clk_en_i) begin
      if (in_mrst) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        count_q  <= '0;
      end else begin
        if (push) begin
          wr_ptr_q <= wr_ptr_q + 1'b1;
        end
        if (load) begin
          rd_ptr_q <= rd_ptr_q + 1'b1;
        end
        unique case ({push, load})
          2'b10:   count_q <= count_q + 1'b1;
          2'b01:   count_q <= count_q - 1'b1;
          default: count_q <= count_q;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Output long-word and lane sequencing
  // --------------------------------------------------------------------
  logic [`FIFO_DATA_W-1:0] out_word_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      out_word_q  <= '0;
      out_valid_q <= 1'b0;
      lane_q      <= 2'h0;
      rem_q       <= 2'h0;
    end else if (clk_en_i) begin
      if (in_mrst) begin
        out_word_q  <= '0;
        out_valid_q <= 1'b0;
        lane_q      <= 2'h0;
        rem_q       <= 2'h0;
      end else if (load) begin
        out_word_q  <= mem_q[rd_ptr_q];  // [R12]
        out_valid_q <= 1'b1;
        lane_q      <= 2'h0;
        rem_q       <= lanes_m1;  // [R9]
      end else if (adv) begin
        lane_q <= lane_q + 2'h1;
        rem_q  <= rem_q - 2'h1;
      end else if (fw_drain) begin
        out_valid_q <= 1'b0;  // [R18]
      end
    end
  end

  // --------------------------------------------------------------------
  // Lane selection
  // --------------------------------------------------------------------
  // Narrow parts sit in the low bits; upper bits drive zero.
  function automatic logic [`FIFO_DATA_W-1:0] pick_lane(
    input logic [`FIFO_DATA_W-1:0] word,
    input logic [1:0]              lane,
    input logic [1:0]              last,
    input logic                    big,
    input fifo_port_pkg::width_mode_e mode
  );
    logic [1:0]              pos;
    logic [`FIFO_DATA_W-1:0] res;
    pos = big ? (last - lane) : lane;  // [R5] [R6]
    res = '0;
    unique case (mode)
      fifo_port_pkg::WIDTH_LONG: res = word;
      fifo_port_pkg::WIDTH_WORD: begin
        res[`FIFO_WORD_W-1:0] = pos[0] ? word[35:18] : word[17:0];
      end
      fifo_port_pkg::WIDTH_BYTE: begin
        unique case (pos)
          2'h0: res[`FIFO_BYTE_W-1:0] = word[8:0];
          2'h1: res[`FIFO_BYTE_W-1:0] = word[17:9];
          2'h2: res[`FIFO_BYTE_W-1:0] = word[26:18];
          2'h3: res[`FIFO_BYTE_W-1:0] = word[35:27];
        endcase
      end
      default: res = word;
    endcase
    return res;
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      read_port_data_o <= '0;
    end else if (clk_en_i) begin
      read_port_data_o <= pick_lane(out_word_q, lane_q, lanes_m1,
                                    big_endian_q, width_mode_q);  // [R4]
    end
  end

  // --------------------------------------------------------------------
  // Output enables
  // --------------------------------------------------------------------
  // The write bus is input only, so this side never drives it.
  assign write_port_data_oe_o = 1'b0;  // [R14]
  assign read_port_data_oe_o  = ~rsel_n_s;  // [R16]

  // --------------------------------------------------------------------
  // Combined flags
  // --------------------------------------------------------------------
  // Flags are refreshed one system cycle after the port edge so they
  // reflect the state that edge produced.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      empty_or_out_ready_o <= `RST_EMPTY_OR;
    end else if (clk_en_i) begin
      if (in_mrst) begin
        empty_or_out_ready_o <= `RST_EMPTY_OR;
      end else if (rd_edge_q) begin
        if (fallthrough_q) begin
          empty_or_out_ready_o <= out_valid_q;  // [R18] [R12]
        end else begin
          empty_or_out_ready_o <= mem_nonempty | (rem_q != 2'h0);  // [R17]
        end
      end
    end
  end

  // Low means full in standard mode; high means room in fall-through.
  // Both readings reduce to the same level.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      full_or_in_ready_o <= `RST_FULL_IR;
    end else if (clk_en_i) begin
      if (in_mrst) begin
        full_or_in_ready_o <= `RST_FULL_IR;
      end else if (wr_edge_q) begin
        full_or_in_ready_o <= ~mem_full;  // [R20] [R11]
      end
    end
  end

  // --------------------------------------------------------------------
  // Programmable flags
  // --------------------------------------------------------------------
  logic [`FIFO_CNT_W-1:0] fill;
  logic [`FIFO_CNT_W-1:0] free;

  // A word waiting on the fall-through outputs still counts as stored.
  assign fill = count_q + {{(`FIFO_CNT_W-1){1'b0}},
                           fallthrough_q & out_valid_q};
  assign free = `FIFO_DEPTH - count_q;

  flag_cmp u_almost_empty (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .hold_i    (in_mrst),
    .update_i  (rd_edge_q),  // [R1] [R12]
    .rst_val_i (`RST_ALMOST_EMPTY),
    .value_i   (fill),
    .limit_i   (empty_offset_s),
    .flag_n_o  (almost_empty_n_o)
  );

  flag_cmp u_almost_full (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .clk_en_i  (clk_en_i),
    .hold_i    (in_mrst),
    .update_i  (wr_edge_q),  // [R2] [R11]
    .rst_val_i (`RST_ALMOST_FULL),
    .value_i   (free),
    .limit_i   (full_offset_s),
    .flag_n_o  (almost_full_n_o)
  );

endmodule

// ### fifo_port_regs.svh
// Constants for the dual-clock FIFO port and flag logic.
// Assumes inclusion by bare name from design files only.
`ifndef FIFO_PORT_REGS_SVH
`define FIFO_PORT_REGS_SVH

// ----------------------------------------------------------------------
// Data path geometry
// ----------------------------------------------------------------------
`define FIFO_DATA_W      36
`define FIFO_BYTE_W      9
`define FIFO_WORD_W      18
`define FIFO_DEPTH       11'h400
`define FIFO_ADDR_W      10
`define FIFO_CNT_W       11

// ----------------------------------------------------------------------
// Lane counts minus one per read-side width
// ----------------------------------------------------------------------
`define LANES_M1_LONG    2'h0
`define LANES_M1_WORD    2'h1
`define LANES_M1_BYTE    2'h3

// ----------------------------------------------------------------------
// Synchronised pin bundle: 10 control pins, 2 offsets, 36 data bits
// ----------------------------------------------------------------------
`define PIN_W            68

// ----------------------------------------------------------------------
// Flag values held during master reset
// ----------------------------------------------------------------------
`define RST_EMPTY_OR     1'b0
`define RST_ALMOST_EMPTY 1'b0
`define RST_FULL_IR      1'b0
`define RST_ALMOST_FULL  1'b1

`endif

// ### fifo_port_pkg.sv
// Types shared by the dual-clock FIFO port and flag logic.
// Assumes the constants header is compiled alongside.
package fifo_port_pkg;

  // --------------------------------------------------------------------
  // Read-side bus width
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    WIDTH_LONG,
    WIDTH_WORD,
    WIDTH_BYTE
  } width_mode_e;

endpackage

// ### pin_sync.sv
// Two-stage synchroniser for a bundle of pins from outside the clock.
// Assumes each pin is static long enough to be caught in one piece.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // --------------------------------------------------------------------
  // Stage one is read only by stage two
  // --------------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else if (clk_en_i) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ### flag_cmp.sv
// Registered threshold compare for one programmable flag.
// Assumes value and limit are stable in the system clock domain.
`timescale 1ns/1ps
`include "fifo_port_regs.svh"
module flag_cmp (
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   hold_i,
  input  wire logic                   update_i,
  input  wire logic                   rst_val_i,
  input  wire logic [`FIFO_CNT_W-1:0] value_i,
  input  wire logic [`FIFO_CNT_W-1:0] limit_i,
  output logic                        flag_n_o
);

  // --------------------------------------------------------------------
  // Low while value is at or below the limit
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flag_n_o <= 1'b1;
    end else if (clk_en_i) begin
      if (hold_i) begin
        flag_n_o <= rst_val_i;
      end else if (update_i) begin
        flag_n_o <= !(value_i <= limit_i);
      end
    end
  end

endmodule

// ### port_clock_model.sv
// Port clocks as the controllers on both sides make them.
// Assumes sys_clk_i is the only time base of the bench.
`timescale 1ns/1ps
module port_clock_model #(
  parameter int WR_HALF = 5,
  parameter int RD_HALF = 6
) (
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  output logic      wclk_o,
  output logic      rclk_o
);
  int wn_q;
  int rn_q;
  // Unequal periods so the two port edges drift apart
  always_ff @(posedge sys_clk_i) begin
    wn_q   <= (srst_i || wn_q == WR_HALF - 1) ? 0 : wn_q + 1;
    wclk_o <= srst_i ? 1'b0 : wclk_o ^ (wn_q == WR_HALF - 1);
  end
  always_ff @(posedge sys_clk_i) begin
    rn_q   <= (srst_i || rn_q == RD_HALF - 1) ? 0 : rn_q + 1;
    rclk_o <= srst_i ? 1'b0 : rclk_o ^ (rn_q == RD_HALF - 1);
  end
endmodule

// ### fifo_flags_props.sv
// Assertions on the FIFO port flag block.
// Assumes port clocks run far below sys_clk_i.
`timescale 1ns/1ps
module fifo_flags_props (
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  input wire logic        master_reset_n_i,
  input wire logic        write_port_clk_i,
  input wire logic        read_port_clk_i,
  input wire logic        read_port_select_n_i,
  input wire logic        write_port_data_oe_o,
  input wire logic [35:0] read_port_data_o,
  input wire logic        read_port_data_oe_o,
  input wire logic        empty_or_out_ready_o,
  input wire logic        full_or_in_ready_o,
  input wire logic        almost_empty_n_o,
  input wire logic        almost_full_n_o
);
  logic [5:0] wh_q;
  logic [5:0] rh_q;
  logic       wc_q;
  logic       rc_q;
  logic [3:0] mc_q;
  logic       ok;
  // Recent port clock rises; outputs may only move inside this window
  always_ff @(posedge sys_clk_i) begin
    wc_q <= write_port_clk_i;
    rc_q <= read_port_clk_i;
    wh_q <= {wh_q[4:0], write_port_clk_i & ~wc_q};
    rh_q <= {rh_q[4:0], read_port_clk_i & ~rc_q};
  end
  // Master reset moves flags without a port edge, so skip its tail
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !master_reset_n_i) begin
      mc_q <= 4'h0;
    end else if (mc_q != 4'hf) begin
      mc_q <= mc_q + 4'h1;
    end
  end
  assign ok = mc_q == 4'hf;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  wr_bus_in_a: assert property (!write_port_data_oe_o)
    else $error("write bus driven");
  rd_hiz_a: assert property (
    read_port_select_n_i [*3] |-> !read_port_data_oe_o)
    else $error("read bus driven while deselected");
  mr_flags_a: assert property (
    !master_reset_n_i [*6] |-> almost_full_n_o && !almost_empty_n_o)
    else $error("flags wrong in master reset");
  wr_edge_a: assert property (
    ok && ($changed(full_or_in_ready_o) || $changed(almost_full_n_o))
    |-> |wh_q) else $error("write flag moved off edge");
  rd_edge_a: assert property (
    ok && ($changed(empty_or_out_ready_o) || $changed(almost_empty_n_o))
    |-> |rh_q) else $error("read flag moved off edge");
  rd_data_a: assert property (
    ok && $changed(read_port_data_o) |-> |rh_q)
    else $error("read data moved off edge");
  full_almost_a: assert property (
    ok && $fell(full_or_in_ready_o) |-> !almost_full_n_o)
    else $error("full without almost full");
  empty_almost_a: assert property (
    ok && $fell(empty_or_out_ready_o) |-> !almost_empty_n_o)
    else $error("empty without almost empty");
  fill_c: cover property ($fell(full_or_in_ready_o));
  ready_c: cover property ($rose(empty_or_out_ready_o));
  afull_c: cover property ($fell(almost_full_n_o));
endmodule
bind dual_clock_fifo_port_flags fifo_flags_props fifo_flags_props_inst (
  .sys_clk_i            (sys_clk_i),
  .srst_i               (srst_i),
  .master_reset_n_i     (master_reset_n_i),
  .write_port_clk_i     (write_port_clk_i),
  .read_port_clk_i      (read_port_clk_i),
  .read_port_select_n_i (read_port_select_n_i),
  .write_port_data_oe_o (write_port_data_oe_o),
  .read_port_data_o     (read_port_data_o),
  .read_port_data_oe_o  (read_port_data_oe_o),
  .empty_or_out_ready_o (empty_or_out_ready_o),
  .full_or_in_ready_o   (full_or_in_ready_o),
  .almost_empty_n_o     (almost_empty_n_o),
  .almost_full_n_o      (almost_full_n_o)
);

// ### test_dual_clock_fifo_port_flags.sv
// Self-checking bench for the FIFO port flag block.
// Assumes the clock model and checker are compiled first.
`timescale 1ns/1ps
module test_dual_clock_fifo_port_flags;
  logic        clk, rst, mrn, wc, rc, ws, rs, we, re, sel, bw, sz;
  logic        woe, roe, eo, fi, ne, nf, cb, cm, cz;
  logic [35:0] wd, rd, d;
  logic [35:0] q[$];
  logic [35:0] e[$];
  int          errors, num_checks, seed;
  dual_clock_fifo_port_flags dual_clock_fifo_port_flags_inst (
    .sys_clk_i(clk), .srst_i(rst), .clk_en_i(1'b1),
    .master_reset_n_i(mrn), .write_port_clk_i(wc), .read_port_clk_i(rc),
    .write_port_select_n_i(ws), .read_port_select_n_i(rs),
    .write_port_enable_i(we), .read_port_enable_i(re),
    .write_port_data_i(wd), .endian_or_fallthrough_sel_i(sel),
    .bus_width_match_sel_i(bw), .size_byte_sel_i(sz),
    .almost_empty_offset_i(11'h002), .almost_full_offset_i(11'h002),
    .write_port_data_oe_o(woe), .read_port_data_o(rd),
    .read_port_data_oe_o(roe), .empty_or_out_ready_o(eo),
    .full_or_in_ready_o(fi), .almost_empty_n_o(ne), .almost_full_n_o(nf));
  port_clock_model port_clock_model_inst (
    .sys_clk_i(clk), .srst_i(rst), .wclk_o(wc), .rclk_o(rc));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string n, input logic [35:0] s, x);
    num_checks++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic flags(input logic [3:0] x);
    check("flags", {32'h0, eo, fi, ne, nf},
          {32'h0, x});
  endtask
  // Drive just after a port clock fall, so pins hold a whole period
  task automatic step(input bit r);
    logic p;
    int   n;
    p = r ? rc : wc;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (p && !(r ? rc : wc)) break;
      p = r ? rc : wc;
    end
    if (n == 40) begin
      errors++;
      results();
    end
  endtask
  task automatic wr(input logic s, en, input logic [35:0] v);
    step(1'b0);
    ws = s;
    we = en;
    wd = v;
  endtask
  task automatic rdx(input logic s, en);
    step(1'b1);
    rs = s;
    re = en;
  endtask
  function automatic logic [35:0] rnd();
    logic [63:0] v;
    v = {$random(seed), $random(seed)};
    return v[35:0];
  endfunction
  function automatic logic [35:0] lane(input logic [35:0] v, input int i);
    int w;
    int n;
    w = cm ? (cz ? 9 : 18) : 36;
    n = 36 / w;
    return (v >> ((cb ? n - 1 - i : i) * w)) & ((36'h1 << w) - 36'h1);
  endfunction
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      wr(1'b0, 1'b1, d);
      q.push_back(d);
    end
    wr(1'b0, 1'b0, 36'h0);
    wr(1'b0, 1'b0, 36'h0);
  endtask
  task automatic drain();
    e.delete();
    foreach (q[j]) for (int i = 0; i < (cm ? (cz ? 4 : 2) : 1); i++)
      e.push_back(lane(q[j], i));
    q.delete();
    for (int i = 0; i <= e.size(); i++) begin
      rdx(1'b0, i < e.size());
      if (i > 0) check("read data", rd, e[i-1]);
    end
  endtask
  task automatic mr(input logic b, m, z, std);
    {mrn, ws, we, rs, re} = 5'h0a;
    {sel, bw, sz, cb, cm, cz} = {b, m, z, b, m, z};
    repeat (8) @(posedge clk);
    #1 mrn = 1'b1;
    repeat (4) @(posedge clk);
    #1 sel = std;
    sz = ~z;
    repeat (3) rdx(1'b0, 1'b0);
  endtask
  initial begin
    seed = 21;
    errors = 0;
    num_checks = 0;
    {rst, mrn, ws, rs, we, re, sel, bw, sz} = 9'h1e0;
    wd = 36'h0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    mr(1'b1, 1'b0, 1'b0, 1'b1);
    flags(4'h5);
    wr(1'b1, 1'b1, rnd());
    wr(1'b0, 1'b0, rnd());
    wr(1'b0, 1'b0, 36'h0);
    rdx(1'b0, 1'b0);
    flags(4'h5);
    push(3);
    rdx(1'b0, 1'b0);
    flags(4'hf);
    rdx(1'b0, 1'b1);
    rdx(1'b1, 1'b1);
    d = q.pop_front();
    check("read data", rd, d);
    rdx(1'b0, 1'b0);
    check("refused read", rd, d);
    flags(4'hd);
    drain();
    flags(4'h5);
    push(1021);
    flags(4'hf);
    push(1);
    flags(4'he);
    push(2);
    wr(1'b0, 1'b1, rnd());
    wr(1'b0, 1'b0, 36'h0);
    wr(1'b0, 1'b0, 36'h0);
    flags(4'ha);
    drain();
    flags(4'h5);
    for (int c = 0; c < 4; c++) begin
      mr(c[0], 1'b1, c[1], 1'b1);
      push(2);
      drain();
    end
    mr(1'b0, 1'b0, 1'b0, 1'b0);
    flags(4'h5);
    push(1);
    rdx(1'b0, 1'b0);
    rdx(1'b0, 1'b0);
    check("fall through", rd, q[0]);
    flags(4'hd);
    rdx(1'b0, 1'b1);
    rdx(1'b0, 1'b0);
    rdx(1'b0, 1'b0);
    flags(4'h5);
    check("read oe", {35'h0, roe}, 36'h1);
    rdx(1'b1, 1'b0);
    rdx(1'b1, 1'b0);
    check("read oe", {35'h0, roe}, 36'h0);
    check("write oe", {35'h0, woe}, 36'h0);
    results();
  end
endmodule
